// >>> hdl/rid_decoder.sv
// instruction decode stage: format, class, operands, address and delay slot
`timescale 1ns/1ps
module rid_decoder #(
	parameter int DATA_W = 64
) (
	input  wire logic                 ref_clk,
	input  wire logic                 rst_b,
	input  wire rid_pkg::rid_fetch_type   fetch,
	input  wire logic [DATA_W-1:0]    base_val,
	input  wire rid_pkg::rid_resolve_type resolve,
	output logic [DATA_W-1:0]         imm_val,
	output logic [DATA_W-1:0]         eff_addr,
	output rid_pkg::rid_dec_type      dec
);
	import rid_pkg::*;

	// only the two datapath widths of the architecture levels are served
	if (DATA_W != 64 && DATA_W != 32) begin : g_width_check
		$error("rid_decoder: DATA_W must be 32 or 64");
	end

	typedef struct packed {
		rid_dec_type       dec;
		logic [DATA_W-1:0] imm;
		logic [DATA_W-1:0] ea;
		logic              slot_pend;
		logic              likely_pend;
		logic              res_seen;
		logic              res_taken;
	} rid_state_type;

	rid_state_type st_r;
	rid_state_type st_nxt;

	////////////////////////////////////////////////////////////////////////
	// size of a load/store opcode; top bit says the opcode is one
	function automatic logic [3:0] ldst_size(input logic [5:0] op);
		case (op)
			OP_LB, OP_LBU, OP_SB:                      ldst_size = {1'b1, SZ_B};
			OP_LH, OP_LHU, OP_SH:                      ldst_size = {1'b1, SZ_H};
			OP_LW, OP_LWU, OP_SW, OP_LL, OP_SC:        ldst_size = {1'b1, SZ_W};
			OP_LD, OP_SD, OP_LLD, OP_SCD:              ldst_size = {1'b1, SZ_D};
			OP_LWL, OP_SWL:                            ldst_size = {1'b1, SZ_WL};
			OP_LWR, OP_SWR:                            ldst_size = {1'b1, SZ_WR};
			OP_LDL, OP_SDL:                            ldst_size = {1'b1, SZ_DL};
			OP_LDR, OP_SDR:                            ldst_size = {1'b1, SZ_DR};
			default:                                   ldst_size = {1'b0, SZ_B};
		endcase
	endfunction

	// bytes touched within the doubleword, little-endian lane order
	function automatic logic [BE_W:0] lanes(input rid_size_type sz, input logic [AOFS_W-1:0] a);
		logic [BE_W-1:0] m;
		logic            bad;
		m   = '0;
		bad = 1'b0;
		case (sz)
			SZ_B:  m = 8'h01 << a;
			SZ_H:  begin m = 8'h03 << a; bad = a[0]; end
			SZ_W:  begin m = 8'h0f << a; bad = |a[1:0]; end
			SZ_D:  begin m = 8'hff; bad = |a; end
			SZ_WL: m = (8'h0f << {1'b0, a[1:0]}) & 8'h0f;
			SZ_WR: m = 8'h0f >> {1'b0, a[1:0]};
			SZ_DL: m = 8'hff << a;
			SZ_DR: m = 8'hff >> a;
			default: bad = 1'b1;
		endcase
		if (sz == SZ_WL || sz == SZ_WR)
			m = a[2] ? {m[3:0], 4'h0} : m;
		lanes = {bad, bad ? 8'h00 : m};
	endfunction

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [INSN_W-1:0]  w;
		logic [5:0]         op;
		logic [5:0]         fn;
		logic [4:0]         rt;
		logic [IMM_W-1:0]   imm16;
		logic [DATA_W-1:0]  sext;
		logic [3:0]         lsz;
		logic [BE_W:0]      ln;
		logic               taken;
		rid_dec_type        d;
		w     = fetch.word;
		op    = w[INSN_W-1:OP_LO];
		fn    = w[FN_W-1:0];
		rt    = w[RT_LO +: REG_W];
		imm16 = w[IMM_W-1:0];
		sext  = {{(DATA_W-IMM_W){imm16[IMM_W-1]}}, imm16};
		lsz   = ldst_size(op);
		ln    = lanes(rid_size_type'(lsz[2:0]), AOFS_W'(base_val + sext));
		st_nxt = st_r;
		d = '0;
		d.valid    = fetch.valid;
		d.op       = op;
		d.fn       = fn;
		d.src_a    = w[RS_LO +: REG_W];
		d.src_b    = rt;
		d.target   = w[TGT_W-1:0];
		d.fmt      = FMT_I;
		d.cls      = CL_NONE;
		d.dst      = rt;
		d.b_is_imm = 1'b1;
		d.size     = SZ_B;
		// all three levels share one table, no mode gating
		if (op == OP_SPECIAL) begin
			d.fmt      = FMT_R;
			d.b_is_imm = 1'b0;
			d.use_b    = 1'b1;
			d.dst      = w[RD_LO +: REG_W];
			d.wr_en    = 1'b1;
			if (fn inside {[FN_SLL:FN_SRAV], [FN_DSLLV:FN_DSRAV], [FN_DSLL:FN_DSRA32]}
					&& fn != 6'(FN_SLL + 1) && fn != 6'(FN_SRAV - 2) && fn != 6'(FN_DSLLV + 1)
					&& fn != 6'(FN_DSLL + 1) && fn != 6'(FN_DSLL32 + 1)) begin
				d.cls = CL_SHIFT;
				if ((fn & FN_VAR_BIT) == '0 || fn >= FN_DSLL) begin
					d.use_b = 1'b1;
					d.src_a = ZERO_REG;
					d.shamt = {1'b0, w[SA_LO +: REG_W]};
					if (fn >= FN_DSLL32)
						d.shamt = d.shamt + SHIFT_PLUS32;
				end
			end else if (fn inside {[FN_MD_LO:FN_MD_HI], [FN_HL_LO:FN_HL_HI]}) begin
				d.cls   = CL_MULDIV;
				d.wr_en = fn == FN_HL_LO || fn == 6'(FN_HL_LO + 2);
				d.use_b = fn >= FN_MD_LO;
			end else if (fn inside {[FN_ALU_LO:FN_ALU_MID], [FN_SLT:FN_ALU_HI]}) begin
				d.cls = CL_ALU_REG;
			end else if (fn == FN_JR || fn == FN_JALR) begin
				d.cls    = CL_JUMP;
				d.branch = 1'b1;
				d.use_b  = 1'b0;
				d.wr_en  = fn == FN_JALR;
			end else if (fn == FN_SYNC) begin
				d.cls   = CL_OTHER;
				d.use_b = 1'b0;
				d.wr_en = 1'b0;
			end else begin
				d.reserved = 1'b1;
			end
		end else if (op == OP_J || op == OP_JAL) begin
			d.fmt    = FMT_J;
			d.cls    = CL_JUMP;
			d.branch = 1'b1;
			d.wr_en  = op == OP_JAL;
			d.dst    = LINK_REG;
		end else if (op == OP_REGIMM) begin
			d.cls    = CL_BRANCH;
			d.branch = 1'b1;
			d.likely = rt[RI_LIKELY_BIT];
			d.wr_en  = rt[RI_LINK_BIT];
			d.dst    = LINK_REG;
			d.reserved = |(rt & RI_VALID_MASK);
		end else if (op inside {[OP_BR_LO:OP_BR_HI], [OP_BRL_LO:OP_BRL_HI]}) begin
			d.cls      = CL_BRANCH;
			d.branch   = 1'b1;
			d.likely   = op >= OP_BRL_LO;
			d.use_b    = 1'b1;
			d.b_is_imm = 1'b0;
		end else if (op inside {[OP_AI_LO:OP_LUI], OP_DADDI, OP_DADDIU}) begin
			d.cls   = CL_ALU_IMM;
			d.wr_en = 1'b1;
		end else if (lsz[3]) begin
			d.cls      = CL_LDST;
			d.size     = rid_size_type'(lsz[2:0]);
			d.is_store = op[3];
			d.is_load  = !op[3] || op == OP_SC || op == OP_SCD;
			d.wr_en    = d.is_load;
			d.use_b    = d.is_store;
			d.byte_en  = ln[BE_W-1:0];
			d.addr_err = ln[BE_W];
		end else if (op inside {[OP_COP_LO:OP_COP_HI]}) begin
			d.cls = CL_OTHER;
		end else begin
			d.reserved = 1'b1;
		end
		// a reserved word must not redirect the pipeline either
		if (d.reserved) begin
			d.cls    = CL_NONE;
			d.wr_en  = 1'b0;
			d.branch = 1'b0;
			d.likely = 1'b0;
		end
		if (d.wr_en && d.dst == ZERO_REG)
			d.wr_en = 1'b0;
		// remember the likely branch's outcome if it arrives before the slot word
		if (resolve.valid) begin
			st_nxt.res_seen  = 1'b1;
			st_nxt.res_taken = resolve.taken;
		end
		taken = resolve.valid ? resolve.taken : st_r.res_seen && st_r.res_taken;
		if (fetch.valid) begin
			d.delay_slot = st_r.slot_pend;
			d.nullify    = st_r.slot_pend && st_r.likely_pend && !taken;
			// a branch sitting in a delay slot does not open a new slot
			st_nxt.slot_pend   = d.branch && !st_r.slot_pend && !d.reserved;
			st_nxt.likely_pend = d.likely && !st_r.slot_pend;
			st_nxt.res_seen    = 1'b0;
			st_nxt.res_taken   = 1'b0;
		end
		if (op == OP_LUI)
			st_nxt.imm = {{(DATA_W-2*IMM_W){imm16[IMM_W-1]}}, imm16, {IMM_W{1'b0}}};
		else if (op inside {[OP_ANDI:OP_XORI]})
			st_nxt.imm = {{(DATA_W-IMM_W){1'b0}}, imm16};
		else
			st_nxt.imm = sext;
		st_nxt.ea  = base_val + sext;
		st_nxt.dec = d;
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign dec      = st_r.dec;
	assign imm_val  = st_r.imm;
	assign eff_addr = st_r.ea;
endmodule

// >>> hdl/rid_pkg.sv
// constants, field layouts and carrier types of the instruction decoder
package rid_pkg;
	localparam int INSN_W   = 32;
	localparam int IMM_W    = 16;
	localparam int TGT_W    = 26;
	localparam int REG_W    = 5;
	localparam int OP_LO    = 26;
	localparam int RS_LO    = 21;
	localparam int RT_LO    = 16;
	localparam int RD_LO    = 11;
	localparam int SA_LO    = 6;
	localparam int FN_W     = 6;
	localparam int SHAMT_W  = 6;
	localparam int BE_W     = 8;
	localparam int AOFS_W   = 3;
	localparam logic [REG_W-1:0] LINK_REG = 5'h1f;
	localparam logic [REG_W-1:0] ZERO_REG = 5'h00;

	// primary opcodes
	localparam logic [5:0] OP_SPECIAL = 6'h00;
	localparam logic [5:0] OP_REGIMM  = 6'h01;
	localparam logic [5:0] OP_J       = 6'h02;
	localparam logic [5:0] OP_JAL     = 6'h03;
	localparam logic [5:0] OP_BR_LO   = 6'h04;
	localparam logic [5:0] OP_BR_HI   = 6'h07;
	localparam logic [5:0] OP_AI_LO   = 6'h08;
	localparam logic [5:0] OP_ANDI    = 6'h0c;
	localparam logic [5:0] OP_XORI    = 6'h0e;
	localparam logic [5:0] OP_LUI     = 6'h0f;
	localparam logic [5:0] OP_COP_LO  = 6'h10;
	localparam logic [5:0] OP_COP_HI  = 6'h12;
	localparam logic [5:0] OP_BRL_LO  = 6'h14;
	localparam logic [5:0] OP_BRL_HI  = 6'h17;
	localparam logic [5:0] OP_DADDI   = 6'h18;
	localparam logic [5:0] OP_DADDIU  = 6'h19;
	localparam logic [5:0] OP_LDL     = 6'h1a;
	localparam logic [5:0] OP_LDR     = 6'h1b;
	localparam logic [5:0] OP_LB      = 6'h20;
	localparam logic [5:0] OP_LH      = 6'h21;
	localparam logic [5:0] OP_LWL     = 6'h22;
	localparam logic [5:0] OP_LW      = 6'h23;
	localparam logic [5:0] OP_LBU     = 6'h24;
	localparam logic [5:0] OP_LHU     = 6'h25;
	localparam logic [5:0] OP_LWR     = 6'h26;
	localparam logic [5:0] OP_LWU     = 6'h27;
	localparam logic [5:0] OP_SB      = 6'h28;
	localparam logic [5:0] OP_SH      = 6'h29;
	localparam logic [5:0] OP_SWL     = 6'h2a;
	localparam logic [5:0] OP_SW      = 6'h2b;
	localparam logic [5:0] OP_SDL     = 6'h2c;
	localparam logic [5:0] OP_SDR     = 6'h2d;
	localparam logic [5:0] OP_SWR     = 6'h2e;
	localparam logic [5:0] OP_LL      = 6'h30;
	localparam logic [5:0] OP_LLD     = 6'h34;
	localparam logic [5:0] OP_LD      = 6'h37;
	localparam logic [5:0] OP_SC      = 6'h38;
	localparam logic [5:0] OP_SCD     = 6'h3c;
	localparam logic [5:0] OP_SD      = 6'h3f;

	// register-format function codes
	localparam logic [5:0] FN_SLL     = 6'h00;
	localparam logic [5:0] FN_SRL     = 6'h02;
	localparam logic [5:0] FN_SRAV    = 6'h07;
	localparam logic [5:0] FN_JR      = 6'h08;
	localparam logic [5:0] FN_JALR    = 6'h09;
	localparam logic [5:0] FN_SYNC    = 6'h0f;
	localparam logic [5:0] FN_HL_LO   = 6'h10;
	localparam logic [5:0] FN_HL_HI   = 6'h13;
	localparam logic [5:0] FN_DSLLV   = 6'h14;
	localparam logic [5:0] FN_DSRLV   = 6'h16;
	localparam logic [5:0] FN_DSRAV   = 6'h17;
	localparam logic [5:0] FN_MD_LO   = 6'h18;
	localparam logic [5:0] FN_MD_HI   = 6'h1f;
	localparam logic [5:0] FN_ALU_LO  = 6'h20;
	localparam logic [5:0] FN_ALU_MID = 6'h27;
	localparam logic [5:0] FN_SLT     = 6'h2a;
	localparam logic [5:0] FN_ALU_HI  = 6'h2f;
	localparam logic [5:0] FN_DSLL    = 6'h38;
	localparam logic [5:0] FN_DSRA    = 6'h3b;
	localparam logic [5:0] FN_DSLL32  = 6'h3c;
	localparam logic [5:0] FN_DSRA32  = 6'h3f;
	localparam logic [5:0] FN_VAR_BIT = 6'h04;
	localparam logic [5:0] FN_P32_BIT = 6'h04;
	localparam logic [SHAMT_W-1:0] SHIFT_PLUS32 = 6'h20;

	// branch selector in the rt field of REGIMM words
	localparam int RI_LIKELY_BIT = 1;
	localparam int RI_LINK_BIT   = 4;
	localparam logic [4:0] RI_VALID_MASK = 5'h0c;

	typedef enum logic [1:0] {FMT_I, FMT_J, FMT_R} rid_fmt_type;
	typedef enum logic [3:0] {CL_NONE, CL_ALU_IMM, CL_ALU_REG, CL_SHIFT, CL_MULDIV,
		CL_LDST, CL_BRANCH, CL_JUMP, CL_OTHER} rid_cls_type;
	typedef enum logic [2:0] {SZ_B, SZ_H, SZ_W, SZ_D, SZ_WL, SZ_WR, SZ_DL, SZ_DR} rid_size_type;

	typedef struct packed {
		logic              valid;
		logic [INSN_W-1:0] word;
	} rid_fetch_type;

	typedef struct packed {
		logic valid;
		logic taken;
	} rid_resolve_type;

	typedef struct packed {
		logic               valid;
		rid_fmt_type        fmt;
		rid_cls_type        cls;
		logic [REG_W-1:0]   src_a;
		logic [REG_W-1:0]   src_b;
		logic               use_b;
		logic [REG_W-1:0]   dst;
		logic               wr_en;
		logic               b_is_imm;
		logic [SHAMT_W-1:0] shamt;
		logic [5:0]         op;
		logic [5:0]         fn;
		logic [TGT_W-1:0]   target;
		logic               is_load;
		logic               is_store;
		rid_size_type       size;
		logic [BE_W-1:0]    byte_en;
		logic               addr_err;
		logic               branch;
		logic               likely;
		logic               delay_slot;
		logic               nullify;
		logic               reserved;
	} rid_dec_type;
endpackage

// >>> tb/rid_decoder_sva.sv
// assertion checker watching the instruction decoder ports
`timescale 1ns/1ps
module rid_decoder_sva #(
	parameter int DATA_W = 64
) (
	input wire logic                     ref_clk,
	input wire logic                     rst_b,
	input wire rid_pkg::rid_fetch_type   fetch,
	input wire logic [DATA_W-1:0]        base_val,
	input wire rid_pkg::rid_resolve_type resolve,
	input wire logic [DATA_W-1:0]        imm_val,
	input wire logic [DATA_W-1:0]        eff_addr,
	input wire rid_pkg::rid_dec_type     dec
);
	import rid_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	wire mem = dec.valid && (dec.is_load || dec.is_store);
	////////////////////////////////////////////////////////////////
	word_taken_a: assert property (fetch.valid |=> dec.valid) else $error("word not answered");
	idle_quiet_a: assert property (!fetch.valid |=> !dec.valid) else $error("answer without word");
	addr_sum_a: assert property (fetch.valid ##1 mem |->
		eff_addr == $past(base_val) + DATA_W'($signed($past(fetch.word[15:0])))) else $error("bad address");
	jump_target_a: assert property (fetch.valid ##1 dec.fmt == FMT_J |->
		dec.target == $past(fetch.word[25:0])) else $error("bad jump target");
	align_fault_a: assert property (mem |-> dec.addr_err == (dec.size == SZ_H ? eff_addr[0] :
		dec.size == SZ_W ? |eff_addr[1:0] : dec.size == SZ_D ? |eff_addr[2:0] : 1'b0)) else $error("bad fault");
	fault_lanes_a: assert property (mem && dec.addr_err |-> dec.byte_en == 8'h00) else $error("lanes on fault");
	plus32_shift_a: assert property (fetch.valid && fetch.word[31:26] == OP_SPECIAL &&
		fetch.word[5:0] == FN_DSLL32 |=> dec.cls == CL_SHIFT && dec.shamt == {1'b1, $past(fetch.word[10:6])})
		else $error("bad plus32 amount");
	reserved_idle_a: assert property (dec.valid && dec.reserved |->
		!dec.wr_en && dec.cls == CL_NONE) else $error("reserved word acts");
	slot_follow_a: assert property (dec.valid && dec.branch && !dec.delay_slot ##1 dec.valid |->
		dec.delay_slot) else $error("slot not marked");
	plain_slot_a: assert property (dec.valid && dec.branch && !dec.likely && !dec.delay_slot ##1
		dec.valid |-> !dec.nullify) else $error("plain slot nullified");
	likely_null_a: assert property (dec.valid && dec.likely && !dec.delay_slot && resolve.valid
		##1 dec.valid |-> dec.nullify == !$past(resolve.taken)) else $error("bad nullify");
	reg_result_a: assert property (dec.valid && dec.cls == CL_ALU_REG |->
		dec.wr_en == (dec.dst != ZERO_REG)) else $error("bad result write");
endmodule
bind rid_decoder rid_decoder_sva #(.DATA_W(DATA_W)) u_sva (.ref_clk(ref_clk), .rst_b(rst_b), .fetch(fetch),
	.base_val(base_val), .resolve(resolve), .imm_val(imm_val), .eff_addr(eff_addr), .dec(dec));

// >>> tb/rid_fetch_model.sv
// fetch-stage model presenting words, base values and likely-branch outcomes
`timescale 1ns/1ps
module rid_fetch_model (
	input  wire logic                ref_clk,
	output rid_pkg::rid_fetch_type   fetch,
	output logic [63:0]              base_val,
	output rid_pkg::rid_resolve_type resolve
);
	import rid_pkg::*;
	initial begin
		fetch = '0;
		base_val = '0;
		resolve = '0;
	end
	// one whole 32-bit word per cycle
	task automatic put(input logic [31:0] w, input logic [63:0] b, input logic rv, input logic rt);
		@(negedge ref_clk);
		fetch.valid = 1'b1;
		fetch.word = w;
		base_val = b;
		resolve.valid = rv;
		resolve.taken = rt;
	endtask
	// idle lines flip so a stale value never looks like a held one
	task automatic idle();
		@(negedge ref_clk);
		fetch.valid = 1'b0;
		fetch.word = ~fetch.word;
		base_val = ~base_val;
		resolve.valid = 1'b0;
		resolve.taken = ~resolve.taken;
	endtask
	// likely-branch outcome on its own, in a cycle without a word
	task automatic pulse(input logic rv, input logic rt);
		@(negedge ref_clk);
		fetch.valid = 1'b0;
		fetch.word = ~fetch.word;
		resolve.valid = rv;
		resolve.taken = rt;
	endtask
endmodule

// >>> tb/test_risc_instruction_decoder.sv
// self-checking testbench for the instruction decoder
`timescale 1ns/1ps
module test_risc_instruction_decoder;
	import rid_pkg::*;
	logic            ref_clk = 1'b0;
	logic            rst_b = 1'b0;
	int              n_fail = 0;
	int              n_checks = 0;
	int              cyc = 0;
	rid_fetch_type   fetch;
	rid_resolve_type resolve;
	rid_dec_type     dec;
	logic [63:0]     base_val;
	logic [63:0]     imm_val;
	logic [63:0]     eff_addr;
	always #4 ref_clk = ~ref_clk;
	rid_fetch_model fm (.ref_clk(ref_clk), .fetch(fetch), .base_val(base_val), .resolve(resolve));
	rid_decoder #(.DATA_W(64)) dut (.ref_clk(ref_clk), .rst_b(rst_b), .fetch(fetch), .base_val(base_val),
		.resolve(resolve), .imm_val(imm_val), .eff_addr(eff_addr), .dec(dec));
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [63:0] s, input logic [63:0] e);
		n_checks++;
		if (s !== e) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic one(input logic [31:0] w);
		fm.put(w, 64'h1000, 1'b0, 1'b0);
		fm.idle();
	endtask
	////////////////////////////////////////////////////////////////
	task automatic s_ldst();
		logic [5:0]   ops [5] = '{OP_LW, OP_LH, OP_SD, OP_LB, OP_LL};
		logic [15:0]  imm [5] = '{16'h0004, 16'h0001, 16'hfff8, 16'h0007, 16'h0008};
		logic [7:0]   bes [5] = '{8'hf0, 8'h00, 8'hff, 8'h80, 8'h0f};
		rid_size_type szs [5] = '{SZ_W, SZ_H, SZ_D, SZ_B, SZ_W};
		for (int i = 0; i < 5; i++) begin
			one({ops[i], 5'h02, 5'h03, imm[i]});
			chk(eff_addr, 64'h1000 + 64'($signed(imm[i])));
			chk(dec.byte_en, bes[i]);
			chk(dec.addr_err, i == 1);
			chk(dec.size, szs[i]);
			chk(dec.fmt, FMT_I);
			chk(dec.cls, CL_LDST);
			chk(dec.is_load, !ops[i][3]);
			chk(dec.is_store, ops[i][3]);
		end
		$display("load store test done");
	endtask
	task automatic s_comp();
		logic [5:0] fns [3] = '{FN_DSLL32, 6'h3e, FN_DSRA32};
		one({OP_SPECIAL, 5'h01, 5'h02, 5'h03, 5'h00, 6'h21});
		chk(dec.fmt, FMT_R);
		chk({dec.op, dec.fn}, {OP_SPECIAL, 6'h21});
		chk(dec.cls, CL_ALU_REG);
		chk({dec.src_a, dec.src_b, dec.dst, dec.wr_en, dec.use_b}, {5'h01, 5'h02, 5'h03, 1'b1, 1'b1});
		one({OP_ANDI, 5'h04, 5'h05, 16'h8001});
		chk(dec.cls, CL_ALU_IMM);
		chk(imm_val, 64'h8001);
		chk({dec.src_a, dec.dst, dec.b_is_imm}, {5'h04, 5'h05, 1'b1});
		one({OP_AI_LO, 5'h04, 5'h05, 16'h8001});
		chk(imm_val, 64'hffff_ffff_ffff_8001);
		for (int i = 0; i < 3; i++) begin
			one({OP_SPECIAL, 5'h09, 5'h06, 5'h07, 5'h05, fns[i]});
			chk(dec.cls, CL_SHIFT);
			chk(dec.shamt, 6'h25);
			chk({dec.src_a, dec.src_b, dec.use_b}, {5'h00, 5'h06, 1'b1});
		end
		one({OP_SPECIAL, 5'h01, 5'h02, 10'h000, 6'h18});
		chk({dec.cls, dec.wr_en}, {CL_MULDIV, 1'b0});
		one({OP_J, 26'h123456});
		chk({dec.fmt, dec.target}, {FMT_J, 26'h123456});
		one({6'h3b, 26'h0});
		chk({dec.reserved, dec.wr_en}, 2'b10);
		$display("compute test done");
	endtask
	task automatic s_ctrl();
		one({OP_LUI, 5'h00, 5'h05, 16'h8001});
		chk(imm_val, 64'hffff_ffff_8001_0000);
		chk(dec.cls, CL_ALU_IMM);
		one({OP_SPECIAL, 5'h04, 5'h00, 5'h06, 5'h00, FN_JALR});
		chk({dec.cls, dec.dst, dec.wr_en, dec.branch}, {CL_JUMP, 5'h06, 1'b1, 1'b1});
		// a linking branch sitting in the jump's slot opens no slot of its own
		one({OP_REGIMM, 5'h02, 5'h11, 16'h0010});
		chk({dec.delay_slot, dec.likely, dec.dst, dec.wr_en}, {1'b1, 1'b0, 5'h1f, 1'b1});
		chk(dec.cls, CL_BRANCH);
		one({OP_SPECIAL, 20'h00000, FN_SYNC});
		chk({dec.delay_slot, dec.cls, dec.reserved, dec.wr_en}, {1'b0, CL_OTHER, 1'b0, 1'b0});
		one({OP_REGIMM, 5'h02, 5'h0c, 16'h0000});
		chk({dec.reserved, dec.cls, dec.branch, dec.wr_en}, {1'b1, CL_NONE, 1'b0, 1'b0});
		one({OP_SPECIAL, 20'h00000, 6'h0c});
		chk({dec.reserved, dec.delay_slot}, 2'b10);
		one({OP_SPECIAL, 5'h01, 5'h02, 5'h00, 5'h00, 6'h21});
		chk({dec.cls, dec.wr_en}, {CL_ALU_REG, 1'b0});
		one({OP_COP_LO, 26'h0});
		chk({dec.cls, dec.reserved}, {CL_OTHER, 1'b0});
		$display("control test done");
	endtask
	task automatic br(input logic [5:0] op, input logic tk);
		fm.put({op, 5'h01, 5'h00, 16'h0004}, 64'h0, 1'b0, 1'b0);
		fm.put({OP_SPECIAL, 5'h01, 5'h02, 5'h03, 5'h00, 6'h21}, 64'h0, 1'b1, tk);
		chk(dec.branch, 1'b1);
		chk(dec.likely, op[4]);
		fm.idle();
		chk(dec.delay_slot, 1'b1);
		chk(dec.nullify, op[4] & ~tk);
	endtask
	// outcome arrives in an empty cycle between the likely branch and its slot
	task automatic gap(input logic rv, input logic tk);
		fm.put({OP_BRL_LO, 5'h01, 5'h00, 16'h0004}, 64'h0, 1'b0, 1'b0);
		fm.pulse(rv, tk);
		fm.put({OP_SPECIAL, 5'h01, 5'h02, 5'h03, 5'h00, 6'h21}, 64'h0, 1'b0, 1'b0);
		fm.idle();
		chk({dec.delay_slot, dec.nullify}, {1'b1, !(rv && tk)});
	endtask
	task automatic s_gap();
		gap(1'b1, 1'b1);
		gap(1'b1, 1'b0);
		gap(1'b0, 1'b1);
		$display("held outcome test done");
	endtask
	// reset in mid-run must drop the slot a branch left pending
	task automatic s_reset();
		fm.put({OP_BRL_LO, 5'h01, 5'h00, 16'h0004}, 64'h0, 1'b0, 1'b0);
		fm.idle();
		rst_b = 1'b0;
		@(negedge ref_clk);
		chk({dec.valid, dec.branch}, 2'b00);
		rst_b = 1'b1;
		one({OP_SPECIAL, 5'h01, 5'h02, 5'h03, 5'h00, 6'h21});
		chk({dec.valid, dec.delay_slot, dec.nullify}, 3'b100);
		$display("reset test done");
	endtask
	task automatic s_branch();
		br(OP_BR_LO, 1'b0);
		br(OP_BR_HI, 1'b0);
		br(OP_BRL_LO, 1'b0);
		br(OP_BRL_LO, 1'b1);
		$display("branch test done");
	endtask
	////////////////////////////////////////////////////////////////
	// ceiling well above the fewer than 100 cycles the tests need
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 2000) begin
			n_fail++;
			stop_test();
		end
	end
	initial begin
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk);
		rst_b = 1'b1;
		s_ldst();
		s_comp();
		s_branch();
		s_ctrl();
		s_gap();
		s_reset();
		stop_test();
	end
endmodule
